// ### smspc_consts.svh
`ifndef SMSPC_CONSTS_SVH
`define SMSPC_CONSTS_SVH
// register byte addresses
`define SMSPC_ADR_CTRL 4'h0
`define SMSPC_ADR_WDATA 4'h4
`define SMSPC_ADR_RDATA 4'h8
`define SMSPC_ADR_STATUS 4'hC
// control register fields
`define SMSPC_CTRL_START 0
`define SMSPC_CTRL_WRITE 1
`define SMSPC_CTRL_ROM 2
`define SMSPC_CTRL_IDX_LO 4
`define SMSPC_CTRL_IDX_HI 5
`define SMSPC_CTRL_LEN_LO 8
`define SMSPC_CTRL_LEN_HI 15
// status register fields
`define SMSPC_ST_BUSY 0
`define SMSPC_ST_PWRDN 1
`define SMSPC_ST_HALTED 2
`define SMSPC_ST_POSTDONE 3
`define SMSPC_ST_CMDERR 4
`define SMSPC_ST_HOSTMODE 5
`define SMSPC_ST_CNT_LO 6
`define SMSPC_ST_CNT_HI 7
`define SMSPC_ST_TESTOK 8
`define SMSPC_RD_VALID 8
// timing: read/write clock half period
`define SMSPC_CLK_NS 100
`define SMSPC_SHCLK_HALF_NS 200
`define SMSPC_SHCLK_HALF_CYC ((`SMSPC_SHCLK_HALF_NS + `SMSPC_CLK_NS - 1) / `SMSPC_CLK_NS)
// widths and buffer depth
`define SMSPC_BITS_PER_WORD 4'h8
`define SMSPC_SYNC_W 8
`define SMSPC_BUF_DEPTH 2'h2
`endif

// ### smspc_pkg.sv
package smspc_pkg;
    typedef enum logic [2:0] {
        SMSPC_IDLE,
        SMSPC_SHIFT,
        SMSPC_PUSH,
        SMSPC_HALT,
        SMSPC_FINISH
    } smspc_eng_t;
    typedef logic [7:0] smspc_word_t;
endpackage : smspc_pkg

// ### smspc_sync.sv
`include "smspc_consts.svh"
module smspc_sync (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset
    input wire logic [`SMSPC_SYNC_W-1:0] async, // pins from outside
    output logic [`SMSPC_SYNC_W-1:0] synced // after two flops
);
    logic [`SMSPC_SYNC_W-1:0] stage1_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= '0;
            synced <= '0;
        end else begin
            stage1_r <= async;
            synced <= stage1_r;
        end
    end
endmodule : smspc_sync

// ### smspc_buf.sv
`include "smspc_consts.svh"
module smspc_buf
    import smspc_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset
    input wire smspc_pkg::smspc_word_t inData, // word from shifter
    input wire logic inValid, // word offered
    output logic inReady, // room for a word
    output smspc_pkg::smspc_word_t outData, // oldest word
    output logic outValid, // a word is held
    input wire logic outReady // reader takes oldest
);
    smspc_word_t mem [2];
    logic [1:0] count_r;
    logic wrPtr_r;
    logic rdPtr_r;
    wire logic push = inValid && inReady;
    wire logic pop = outValid && outReady;
    assign inReady = (count_r != `SMSPC_BUF_DEPTH);
    assign outValid = (count_r != 2'h0);
    assign outData = mem[rdPtr_r];
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) wrPtr_r <= !wrPtr_r;
            if (pop) rdPtr_r <= !rdPtr_r;
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_buf_no_overflow: assert property (count_r <= `SMSPC_BUF_DEPTH)
        else $error("buffer count beyond depth");
    a_buf_full_stall: assert property ((count_r == `SMSPC_BUF_DEPTH) && !pop |=> !inReady)
        else $error("buffer accepts while full");
endmodule : smspc_buf

// ### smspc_top.sv
// Our own choices: the address map and the Wishbone slave port.
`include "smspc_consts.svh"
// Function
// - data line drives write bits and samples read-back bits of serial registers
// - voice ROM read data comes in on its own input line
// - four active-low memory selects, one per external memory
// - mode input low means stand-alone, high means host interface mode
// - reset input high clears internal state and enters power-down; the code keeps postDone_r, cmdErr_r and the read buffer
// - power-down input low enters power-down without clearing state
// - power-down while writing halts; on release the write is completed
// - active-low write select chooses between read and write
// - read/write clock shifts data out of or into the memories
module smspc_top
    import smspc_pkg::*;
(
    input wire logic clock, // 10 MHz system clock
    input wire logic reset_n, // async reset
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [3:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic memoryDataIn, // data line level
    output logic memoryDataOut, // data line drive value
    output logic memoryDataOe_n, // low while driving the line
    input wire logic romSerialDataIn, // voice rom serial data
    output logic memorySelect1_n, // memory select 1
    output logic memorySelect2_n, // memory select 2
    output logic memorySelect3_n, // memory select 3
    output logic memorySelect4_n, // memory select 4
    output logic memoryWriteSel_n, // low selects write
    output logic memoryRwClock, // read/write shift clock
    input wire logic memoryCountSelLo, // fitted count, low bit
    input wire logic memoryCountSelHi, // fitted count, high bit
    input wire logic hostInterfaceModeSel, // high: host mode
    input wire logic powerDownRequest_n, // low: power down
    input wire logic chipResetRequest, // high: reset and power down
    input wire logic testLowPin, // must be low in use
    input wire logic testHighPin // must be high in use
);
    // =====================================================
    // pin synchronisers
    // =====================================================
    logic [`SMSPC_SYNC_W-1:0] syn;
    smspc_sync uSync (
        .clock(clock),
        .reset_n(reset_n),
        .async({testHighPin, testLowPin, chipResetRequest, powerDownRequest_n,
                hostInterfaceModeSel, memoryCountSelHi, memoryCountSelLo,
                memoryDataIn}),
        .synced(syn)
    );
    // rom line needs its own stage; keep it separate from the shared vector
    logic romS1_r;
    logic romS2_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            romS1_r <= 1'b0;
            romS2_r <= 1'b0;
        end else begin
            romS1_r <= romSerialDataIn;
            romS2_r <= romS1_r;
        end
    end
    wire logic [1:0] fittedIdx = syn[2:1];
    wire logic hostMode = syn[3];
    wire logic pdReq = !syn[4];
    wire logic chipRst = syn[5];
    wire logic testOk = !syn[6] && syn[7];
    // =====================================================
    // wishbone slave
    // =====================================================
    logic ack_r;
    logic [31:0] rdat_r;
    wire logic access = wb_cyc_i && wb_stb_i && !ack_r;
    wire logic wrAcc = access && wb_we_i;
    wire logic ctrlWr = wrAcc && (wb_adr_i == `SMSPC_ADR_CTRL) && wb_sel_i[0];
    wire logic rdPop = access && !wb_we_i && (wb_adr_i == `SMSPC_ADR_RDATA);
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    // =====================================================
    // engine and control state
    // =====================================================
    smspc_eng_t engState_r;
    smspc_word_t shReg_r;
    smspc_word_t wdata_r;
    logic [7:0] bytesLeft_r;
    logic [3:0] bitCnt_r;
    logic wr_r;
    logic rom_r;
    logic [1:0] idx_r;
    logic rwClk_r;
    logic pwrDown_r;
    logic halted_r;
    logic postDone_r;
    logic cmdErr_r;
    logic [1:0] divCnt_r;
    logic tick;
    logic bufInReady;
    logic bufOutValid;
    smspc_word_t bufOutData;

    function automatic logic idxAllowed(input logic [1:0] idx, input logic rom,
                                        input logic [1:0] fitted);
        idxAllowed = rom || (idx <= fitted);
    endfunction : idxAllowed

    wire logic [1:0] reqIdx = wb_dat_i[`SMSPC_CTRL_IDX_HI:`SMSPC_CTRL_IDX_LO];
    wire logic reqRom = wb_dat_i[`SMSPC_CTRL_ROM];
    // start refused outside host mode, while busy, powered down or out of range
    wire logic startOk = ctrlWr && wb_dat_i[`SMSPC_CTRL_START] && hostMode
        && (engState_r == SMSPC_IDLE) && !pwrDown_r && !pdReq
        && idxAllowed(reqIdx, reqRom, fittedIdx);
    wire logic startBad = ctrlWr && wb_dat_i[`SMSPC_CTRL_START] && !startOk;

    // rw clock rate divider: one enable per half period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_r <= 2'h0;
            tick <= 1'b0;
        end else if (divCnt_r == 2'(`SMSPC_SHCLK_HALF_CYC - 1)) begin
            divCnt_r <= 2'h0;
            tick <= 1'b1;
        end else begin
            divCnt_r <= divCnt_r + 2'h1;
            tick <= 1'b0;
        end
    end

    // power-down follows the pins; reset pin also clears the engine
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pwrDown_r <= 1'b1;
        end else begin
            pwrDown_r <= chipRst || pdReq;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wdata_r <= 8'h00;
        end else if (wrAcc && (wb_adr_i == `SMSPC_ADR_WDATA) && wb_sel_i[0]) begin
            wdata_r <= wb_dat_i[7:0];
        end
    end

    // the first shift edge waits until the select pin is already low, so the
    // synchronised read line holds the memory's first bit when it is sampled
    wire logic selDriven = ({memorySelect4_n, memorySelect3_n, memorySelect2_n,
                             memorySelect1_n} != 4'hF);
    wire logic readBit = rom_r ? romS2_r : syn[0];
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            engState_r <= SMSPC_IDLE;
            shReg_r <= 8'h00;
            bytesLeft_r <= 8'h00;
            bitCnt_r <= 4'h0;
            wr_r <= 1'b0;
            rom_r <= 1'b0;
            idx_r <= 2'h0;
            rwClk_r <= 1'b0;
            halted_r <= 1'b0;
        end else if (chipRst) begin
            engState_r <= SMSPC_IDLE;
            bitCnt_r <= 4'h0;
            rwClk_r <= 1'b0;
            halted_r <= 1'b0;
        end else begin
            unique case (engState_r)
                SMSPC_IDLE: begin
                    if (startOk) begin
                        engState_r <= SMSPC_SHIFT;
                        wr_r <= wb_dat_i[`SMSPC_CTRL_WRITE];
                        rom_r <= reqRom && !wb_dat_i[`SMSPC_CTRL_WRITE];
                        idx_r <= reqIdx;
                        bytesLeft_r <= wb_dat_i[`SMSPC_CTRL_LEN_HI:`SMSPC_CTRL_LEN_LO];
                        shReg_r <= wdata_r;
                        bitCnt_r <= 4'h0;
                    end
                end
                SMSPC_SHIFT: begin
                    if (pdReq && !rwClk_r) begin
                        engState_r <= SMSPC_HALT;
                        halted_r <= 1'b1;
                    end else if (tick && !rwClk_r && bitCnt_r == `SMSPC_BITS_PER_WORD) begin
                        engState_r <= wr_r ? SMSPC_FINISH : SMSPC_PUSH;
                    end else if (tick && !rwClk_r && selDriven) begin
                        rwClk_r <= 1'b1;
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end else if (tick && rwClk_r) begin
                        // read bits taken mid-bit: the two-flop delay eats the first half
                        rwClk_r <= 1'b0;
                        shReg_r <= {shReg_r[6:0], wr_r ? 1'b0 : readBit};
                    end
                end
                SMSPC_PUSH: begin
                    // stalls here while the read buffer is full or power-down is asked
                    if (bufInReady && !pdReq) begin
                        bitCnt_r <= 4'h0;
                        if (bytesLeft_r <= 8'h01) begin
                            engState_r <= SMSPC_FINISH;
                        end else begin
                            bytesLeft_r <= bytesLeft_r - 8'h01;
                            engState_r <= SMSPC_SHIFT;
                        end
                    end
                end
                SMSPC_HALT: begin
                    if (!pdReq) begin
                        engState_r <= SMSPC_SHIFT;
                        halted_r <= 1'b0;
                    end
                end
                SMSPC_FINISH: begin
                    engState_r <= SMSPC_IDLE;
                    rwClk_r <= 1'b0;
                end
            endcase
        end
    end

    // sticky flags: the set wins over a same-cycle clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            postDone_r <= 1'b0;
            cmdErr_r <= 1'b0;
        end else begin
            if (engState_r == SMSPC_HALT && !pdReq && !chipRst && wr_r) begin
                postDone_r <= 1'b1;
            end else if (wrAcc && wb_adr_i == `SMSPC_ADR_STATUS && wb_sel_i[0]
                         && wb_dat_i[`SMSPC_ST_POSTDONE]) begin
                postDone_r <= 1'b0;
            end
            if (startBad) begin
                cmdErr_r <= 1'b1;
            end else if (startOk) begin
                cmdErr_r <= 1'b0;
            end
        end
    end

    // =====================================================
    // pins: registered from engine state
    // =====================================================
    wire logic active = (engState_r != SMSPC_IDLE);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            memoryDataOe_n <= 1'b1;
            memoryDataOut <= 1'b0;
            memoryWriteSel_n <= 1'b1;
            memoryRwClock <= 1'b0;
            {memorySelect4_n, memorySelect3_n, memorySelect2_n, memorySelect1_n} <= 4'hF;
        end else begin
            memoryDataOe_n <= !(engState_r == SMSPC_SHIFT && wr_r);
            memoryDataOut <= shReg_r[7];
            memoryWriteSel_n <= !(active && wr_r);
            memoryRwClock <= rwClk_r;
            memorySelect1_n <= !(active && idx_r == 2'h0);
            memorySelect2_n <= !(active && idx_r == 2'h1);
            memorySelect3_n <= !(active && idx_r == 2'h2);
            memorySelect4_n <= !(active && idx_r == 2'h3);
        end
    end

    // =====================================================
    // read buffer
    // =====================================================
    smspc_buf uBuf (
        .clock(clock),
        .reset_n(reset_n),
        .inData(shReg_r),
        .inValid(engState_r == SMSPC_PUSH),
        .inReady(bufInReady),
        .outData(bufOutData),
        .outValid(bufOutValid),
        .outReady(rdPop)
    );

    // =====================================================
    // bus answer
    // =====================================================
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= access;
            if (access && !wb_we_i) begin
                unique case (wb_adr_i)
                    `SMSPC_ADR_CTRL: rdat_r <= {16'h0000, bytesLeft_r, 2'h0, idx_r,
                                                1'b0, rom_r, wr_r, active};
                    `SMSPC_ADR_WDATA: rdat_r <= {24'h00_0000, wdata_r};
                    `SMSPC_ADR_RDATA: rdat_r <= {23'h00_0000, bufOutValid, bufOutData};
                    `SMSPC_ADR_STATUS: rdat_r <= {23'h00_0000, testOk, fittedIdx,
                                                  hostMode, cmdErr_r, postDone_r,
                                                  halted_r, pwrDown_r, active};
                    default: rdat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // =====================================================
    // checks
    // =====================================================
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_start;
        (engState_r == SMSPC_IDLE) ##1 (engState_r == SMSPC_SHIFT);
    endsequence
    sequence s_halt_release;
        (engState_r == SMSPC_HALT && pdReq) ##1 (!pdReq && !chipRst);
    endsequence
    a_select_one_low: assert property ($countones({memorySelect4_n, memorySelect3_n,
        memorySelect2_n, memorySelect1_n}) >= 3)
        else $error("two memory selects low");
    a_select_in_count: assert property (active && !rom_r |-> idx_r <= fittedIdx)
        else $error("select beyond fitted count");
    a_line_released: assert property (!(engState_r == SMSPC_SHIFT && wr_r) |=> memoryDataOe_n)
        else $error("data line driven outside write");
    a_reset_clears: assert property (chipRst |=> pwrDown_r && engState_r == SMSPC_IDLE)
        else $error("reset pin did not clear");
    a_pd_enter: assert property (pdReq && !chipRst |=> pwrDown_r && $stable(bytesLeft_r))
        else $error("power down not entered");
    a_halt_resume: assert property (s_halt_release |=> engState_r == SMSPC_SHIFT)
        else $error("halt not resumed");
    a_write_select: assert property (active && wr_r |=> !memoryWriteSel_n)
        else $error("write select not low");
    a_shclk_start_low: assert property (s_start |-> !rwClk_r ##1 !memoryRwClock)
        else $error("shift clock not low at start");
    a_standalone_ignore: assert property (ctrlWr && !hostMode |=> !(engState_r == SMSPC_SHIFT
        && $past(engState_r) == SMSPC_IDLE))
        else $error("start accepted in stand-alone mode");
endmodule : smspc_top

// ### smspc_mem_model.sv
module smspc_mem_model (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset
    input wire logic [3:0] selN, // four active-low selects
    input wire logic writeSel_n, // low: write
    input wire logic rwClock, // shift clock
    input wire logic driveBit, // device drive value
    input wire logic driveOe_n, // device drives when low
    output logic lineLevel, // resolved data line
    output logic romBit // voice rom data line
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // serial registers and voice roms, one byte each
    localparam logic [7:0] ROM_BASE = 8'h96;
    logic [7:0] mem [4];
    logic [7:0] romWord;
    logic [1:0] idx;
    logic [2:0] bitCnt;
    logic picked;
    logic rwPrev;
    logic lastLine;
    always_comb begin
        picked = (selN != 4'hF);
        idx = selN[0] ? (selN[1] ? (selN[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
        romWord = ROM_BASE + {6'h00, idx};
    end
    // a released line toggles so a stale bit never passes as read data
    always_comb begin
        if (driveOe_n === 1'h0) begin
            lineLevel = driveBit;
        end else if (picked && writeSel_n) begin
            lineLevel = mem[idx][3'h7 - bitCnt];
        end else begin
            lineLevel = ~lastLine;
        end
        romBit = picked ? romWord[3'h7 - bitCnt] : ~lastLine;
    end
    // edges seen one cycle late: data is stable two cycles either side
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rwPrev <= 1'h0;
            lastLine <= 1'h0;
            bitCnt <= 3'h0;
        end else begin
            rwPrev <= rwClock;
            lastLine <= lineLevel;
            if (!picked) begin
                bitCnt <= 3'h0;
            end else if (rwClock && !rwPrev) begin
                bitCnt <= bitCnt + 3'h1;
                if (!writeSel_n) begin
                    mem[idx] <= {mem[idx][6:0], lineLevel};
                end
            end
        end
    end
endmodule : smspc_mem_model

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import smspc_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m;} smspc_exp_t;
    // ==========
    // stimulus and wiring
    logic clock = 1'h0;
    logic clkRun = 1'h1;
    logic reset_n = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, dataIn, dataOut, dataOe_n, romIn, writeSel_n, rwClock;
    logic [3:0] selN;
    logic cntLo = 1'h1, cntHi = 1'h1, hostMode = 1'h1, pdN = 1'h1, chipRst = 1'h0;
    logic testLo = 1'h0, testHi = 1'h1;
    logic [1:0] expIdx = 2'h0;
    logic [7:0] wbyte [4];
    int fails = 0, tests_run = 0, seed = 41;
    smspc_exp_t expQ[$];
    always #50 clock = clkRun ? ~clock : 1'h0;
    smspc_top smspc_top_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .memoryDataIn(dataIn), .memoryDataOut(dataOut), .memoryDataOe_n(dataOe_n),
        .romSerialDataIn(romIn), .memorySelect1_n(selN[0]), .memorySelect2_n(selN[1]),
        .memorySelect3_n(selN[2]), .memorySelect4_n(selN[3]), .memoryWriteSel_n(writeSel_n),
        .memoryRwClock(rwClock), .memoryCountSelLo(cntLo), .memoryCountSelHi(cntHi),
        .hostInterfaceModeSel(hostMode), .powerDownRequest_n(pdN),
        .chipResetRequest(chipRst), .testLowPin(testLo), .testHighPin(testHi));
    smspc_mem_model smspc_mem_model_inst (.clock(clock), .reset_n(reset_n), .selN(selN),
        .writeSel_n(writeSel_n), .rwClock(rwClock), .driveBit(dataOut), .driveOe_n(dataOe_n),
        .lineLevel(dataIn), .romBit(romIn));
    // ==========
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check
    task give_verdict;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // hold the request until ack is sampled, then release for a cycle
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 40);
        rd = wb_dat_o;
        if (n >= 40) check(32'h1, 32'h0, "bus hang");
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : bus
    task automatic rdc(input logic [3:0] adr, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(smspc_exp_t'{e, m});
        bus(1'h0, adr, 32'h0);
    endtask : rdc
    task automatic idle;
        logic done;
        done = 1'h0;
        for (int n = 0; n < 300 && !done; n++) begin
            rdc(4'hC, 32'h0, 32'h0);
            done = (rd[0] === 1'h0);
        end
        if (!done) check(32'h1, 32'h0, "engine stuck");
    endtask : idle
    function automatic logic [31:0] ctl(logic w, logic rom, logic [1:0] i, logic [7:0] len);
        return {16'h0, len, 2'h0, i, 1'h0, rom, w, 1'h1};
    endfunction : ctl
    function automatic logic [31:0] st(logic [5:0] flags, logic [1:0] cnt);
        return {23'h0, 1'h1, cnt, flags};
    endfunction : st
    // ==========
    // monitor: oldest note against each read answer, pins every cycle
    always @(posedge clock) begin
        smspc_exp_t e;
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && expQ.size() > 0) begin
            e = expQ.pop_front();
            if (e.m != 32'h0) check(wb_dat_o & e.m, e.d & e.m, "read value");
        end
        if (reset_n) begin
            check(32'($countones(~selN) > 1), 32'h0, "two selects");
            if (selN !== 4'hF) check({28'h0, selN}, {28'h0, ~(4'h1 << expIdx)}, "select");
            if (dataOe_n === 1'h0) check({31'h0, writeSel_n}, 32'h0, "drive outside write");
        end
    end
    initial begin
        #(30000 * 100);
        check(32'h1, 32'h0, "watchdog");
        give_verdict();
    end
    // ==========
    // scenarios
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'h1;
        repeat (4) @(posedge clock);
        rdc(4'hC, st(6'h20, 2'h3), 32'h1FF);
        for (int i = 0; i < 4; i++) begin
            wbyte[i] = 8'($random(seed));
            expIdx <= 2'(i);
            bus(1'h1, 4'h4, {24'h0, wbyte[i]});
            bus(1'h1, 4'h0, ctl(1'h1, 1'h0, 2'(i), 8'h01));
            idle();
            check({24'h0, smspc_mem_model_inst.mem[i]}, {24'h0, wbyte[i]}, "stored");
            bus(1'h1, 4'h0, ctl(1'h0, 1'h0, 2'(i), 8'h01));
            idle();
            rdc(4'h8, {23'h0, 1'h1, wbyte[i]}, 32'h1FF);
            bus(1'h1, 4'h0, ctl(1'h0, 1'h1, 2'(i), 8'h01));
            idle();
            rdc(4'h8, {23'h0, 1'h1, 8'h96 + 8'(i)}, 32'h1FF);
        end
        // receiver stalls: two words held, third waits in the shifter
        expIdx <= 2'h0;
        bus(1'h1, 4'h0, ctl(1'h0, 1'h0, 2'h0, 8'h03));
        repeat (150) @(posedge clock);
        rdc(4'hC, 32'h1, 32'h1);
        rdc(4'h8, {23'h0, 1'h1, wbyte[0]}, 32'h1FF);
        rdc(4'h8, {23'h0, 1'h1, wbyte[0]}, 32'h1FF);
        idle();
        rdc(4'h8, {23'h0, 1'h1, wbyte[0]}, 32'h1FF);
        rdc(4'h8, 32'h0, 32'h100);
        // start beyond the fitted count is refused for every smaller count
        for (int c = 0; c < 3; c++) begin
            {cntHi, cntLo} <= 2'(c);
            repeat (4) @(posedge clock);
            bus(1'h1, 4'h0, ctl(1'h1, 1'h0, 2'(c + 1), 8'h01));
            repeat (4) @(posedge clock);
            rdc(4'hC, st(6'h30, 2'(c)), 32'h1FF);
        end
        {cntHi, cntLo} <= 2'h3;
        hostMode <= 1'h0;
        repeat (4) @(posedge clock);
        bus(1'h1, 4'h0, ctl(1'h1, 1'h0, 2'h0, 8'h01));
        repeat (4) @(posedge clock);
        rdc(4'hC, 32'h0, 32'h21);
        hostMode <= 1'h1;
        // power down in mid-write halts, then the write completes
        wbyte[1] = 8'($random(seed));
        expIdx <= 2'h1;
        bus(1'h1, 4'h4, {24'h0, wbyte[1]});
        bus(1'h1, 4'h0, ctl(1'h1, 1'h0, 2'h1, 8'h01));
        repeat (10) @(posedge clock);
        pdN <= 1'h0;
        repeat (30) @(posedge clock);
        rdc(4'hC, 32'h7, 32'h7);
        rdc(4'h0, 32'h10, 32'h30);
        check({27'h0, dataOe_n, selN}, {27'h0, 1'h1, 4'hD}, "halted pins");
        pdN <= 1'h1;
        idle();
        rdc(4'hC, 32'h8, 32'h8);
        check({24'h0, smspc_mem_model_inst.mem[1]}, {24'h0, wbyte[1]}, "resumed");
        bus(1'h1, 4'hC, 32'h8);
        rdc(4'hC, 32'h0, 32'h8);
        // chip reset in mid-write abandons it and powers down
        expIdx <= 2'h2;
        bus(1'h1, 4'h0, ctl(1'h1, 1'h0, 2'h2, 8'h01));
        repeat (10) @(posedge clock);
        chipRst <= 1'h1;
        repeat (6) @(posedge clock);
        rdc(4'hC, 32'h2, 32'h3);
        check({27'h0, dataOe_n, selN}, {27'h0, 1'h1, 4'hF}, "reset pins");
        // powered down: the external clock source is held at ground for a while
        clkRun <= 1'h0;
        #3025;
        clkRun = 1'h1;
        @(posedge clock);
        chipRst <= 1'h0;
        repeat (6) @(posedge clock);
        rdc(4'hC, 32'h20, 32'h23);
        give_verdict();
    end
endmodule : testbench
